// >>> e1_tx_payload_consts.svh
`ifndef E1_TX_PAYLOAD_CONSTS_SVH
`define E1_TX_PAYLOAD_CONSTS_SVH
// register indices, byte address is four times the index
`define IDX_IRQ_EN0 8'hC3
`define IDX_IRQ_EN1 8'hC4
`define IDX_FLAGS0 8'hC5
`define IDX_FLAGS1 8'hC6
`define IDX_TEST_CFG 8'hC7
`define IDX_ACC_STAT 8'hC8
`define IDX_ACC_CTRL 8'hC9
`define IDX_ACC_DATA 8'hCA
`define IDX_PL_CFG 8'hCB
`define IDX_PL_EN 8'hCC
// field positions and masks
`define ACC_DIR_BIT 7
`define TEST_START_BIT 0
`define TEST_DIR_BIT 1
`define CFG_SNAP_BIT 7
`define CFG_GSIG_BIT 6
`define CFG_WMASK 8'hC7
`define CFG_RESET 8'h80
`define SLOT_TEST_BIT 6
`define SLOT_SIG_BIT 4
// indirect address limits
`define ID_LAST 7'h5F
`define ID_HOLE0 7'h40
`define ID_HOLE1 7'h50
// busy time of one indirect access, in clock cycles
`define ACC_CYCLES 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> e1_tx_payload_pkg.sv
package e1_tx_payload_pkg;
   typedef enum logic [1:0] {TEST_UNFRAMED, TEST_8BIT, TEST_7BIT, TEST_RSVD} test_mode_e;
   typedef enum logic [2:0] {REPL_SLOT, REPL_TRUNK, REPL_ALAW, REPL_MULAW, REPL_LOOP} repl_e;
   typedef enum logic {ACC_IDLE, ACC_RUN} acc_state_e;
endpackage

// >>> e1_tx_payload_ctrl_regs.sv
// What this block does
// - line code overflow flag reaches interrupt only while its enable bit 0 is set
// - eight sticky overflow flags, one per monitored counter group, bits 7 to 0
// - overflow flag stays set until host writes one; writing zero keeps it
// - bit 0 of second flag register sets on line code overflow; resets 0
// - extraction mode 00 uses all 32 slots, ignoring per-slot test bits
// - mode 01 uses whole bytes only in slots whose test bit is set
// - mode 10 uses seven upper bits of selected slots; 11 is reserved
// - direction 0 generates on transmit, checks receive; 1 swaps them
// - only a zero-to-one edge of start bit starts generator and detector
// - status bit 0 reads one while an indirect access runs; resets 0
// - control bit 7 is direction, 1 read 0 write; bits 6-0 address
// - for reads host writes address with direction 1; data lands in data register
// - snapshot on: signaling from first frame held for whole multiframe; resets 1
// - global signaling conditioning replaces all slots' ABCD, else per-slot enable
// - global replace code 000 follows each slot's own three-bit selection
// - code 001 replaces all slots with the per-slot data conditioning byte
// - code 010 inserts A-law milliwatt, 011 inserts mu-law milliwatt
// - code 100 inserts receive elastic store loopback data; others reserved
// - master enable bit 0, reset 0, gates data and signaling replacement only, not the test mask
`timescale 1ns/1ns
`include "e1_tx_payload_consts.svh"
`default_nettype none
module e1_tx_payload_ctrl_regs
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [7:0] ovf_evt_i,
   input wire logic line_code_ovf_evt_i,
   output logic int_n_o,
   output logic test_start_o,
   output logic test_gen_tx_o,
   output logic test_gen_rx_o,
   output logic [7:0] test_mask_o,
   input wire logic slot_strobe_i,
   input wire logic [4:0] slot_idx_i,
   input wire logic [3:0] frame_idx_i,
   input wire logic [7:0] tx_data_i,
   input wire logic [3:0] tx_sig_i,
   input wire logic [7:0] loopback_data_i,
   output logic [7:0] tx_data_o,
   output logic [3:0] tx_sig_o
);
   logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [9:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [7:0] rdata_q;
   logic [7:0] en0_q, flags0_q, acc_ctrl_q, acc_data_q, pl_cfg_q;
   logic en1_q, flags1_q, pl_en_q, test_prev_q, test_start_q, int_q;
   logic [3:0] test_cfg_q;
   logic [7:0] test_mask_q, tx_data_q;
   logic [3:0] tx_sig_q;
   logic [1:0] acc_cnt_q;
   e1_tx_payload_pkg::acc_state_e acc_state_q;
   logic [7:0] mem_q [0:127];
   logic [3:0] snap_q [0:31];

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave
   wire do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
   wire [7:0] wr_idx = awaddr_q[9:2];
   wire [7:0] ar_idx = s_axi_araddr_i[9:2];
   wire ar_hs = s_axi_arvalid_i & ~rvalid_q;
   wire aw_hs = s_axi_awvalid_i & ~aw_hold_q & ~bvalid_q;
   wire w_hs = s_axi_wvalid_i & ~w_hold_q & ~bvalid_q;
   wire wr_mapped = (wr_idx >= `IDX_IRQ_EN0) && (wr_idx <= `IDX_PL_EN);
   wire ar_mapped = (ar_idx >= `IDX_IRQ_EN0) && (ar_idx <= `IDX_PL_EN)
                    && (s_axi_araddr_i[11:10] == 2'h0);
   wire wr_go = do_wr & wstrb_q;
   wire wr_en0 = wr_go && wr_idx == `IDX_IRQ_EN0;
   wire wr_en1 = wr_go && wr_idx == `IDX_IRQ_EN1;
   wire wr_fl0 = wr_go && wr_idx == `IDX_FLAGS0;
   wire wr_fl1 = wr_go && wr_idx == `IDX_FLAGS1;
   wire wr_test = wr_go && wr_idx == `IDX_TEST_CFG;
   wire wr_ctrl = wr_go && wr_idx == `IDX_ACC_CTRL;
   wire wr_data = wr_go && wr_idx == `IDX_ACC_DATA;
   wire wr_cfg = wr_go && wr_idx == `IDX_PL_CFG;
   wire wr_pen = wr_go && wr_idx == `IDX_PL_EN;
   wire busy = (acc_state_q == e1_tx_payload_pkg::ACC_RUN);
   wire [7:0] rd_mux =
      (ar_idx == `IDX_IRQ_EN0) ? en0_q :
      (ar_idx == `IDX_IRQ_EN1) ? {7'h00, en1_q} :
      (ar_idx == `IDX_FLAGS0) ? flags0_q :
      (ar_idx == `IDX_FLAGS1) ? {7'h00, flags1_q} :
      (ar_idx == `IDX_TEST_CFG) ? {4'h0, test_cfg_q} :
      (ar_idx == `IDX_ACC_STAT) ? {7'h00, busy} :
      (ar_idx == `IDX_ACC_CTRL) ? acc_ctrl_q :
      (ar_idx == `IDX_ACC_DATA) ? acc_data_q :
      (ar_idx == `IDX_PL_CFG) ? pl_cfg_q :
      (ar_idx == `IDX_PL_EN) ? {7'h00, pl_en_q} : 8'h00;

   assign s_axi_awready_o = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready_o = ~w_hold_q & ~bvalid_q;
   assign s_axi_bvalid_o = bvalid_q;
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = ~rvalid_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rresp_o = rresp_q;
   assign s_axi_rdata_o = {24'h000000, rdata_q};

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         bvalid_q <= 1'b0;
         awaddr_q <= 10'h000;
         wdata_q <= 8'h00;
         wstrb_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end
      else
      begin
         if (aw_hs)
         begin
            aw_hold_q <= 1'b1;
            // top address bits are folded into the mapped check here
            awaddr_q <= (s_axi_awaddr_i[11:10] == 2'h0) ? s_axi_awaddr_i[9:0] : 10'h000;
         end
         if (w_hs)
         begin
            w_hold_q <= 1'b1;
            wdata_q <= s_axi_wdata_i[7:0];
            wstrb_q <= s_axi_wstrb_i[0];
         end
         if (do_wr)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready_i)
            bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 8'h00;
         rresp_q <= `RESP_OKAY;
      end
      else if (ar_hs)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= ar_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready_i)
         rvalid_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // overflow flags and interrupt
   wire [7:0] irq_src = flags0_q & en0_q;
   wire any_irq = (|irq_src) | (flags1_q & en1_q);

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         en0_q <= 8'h00;
         en1_q <= 1'b0;
         flags0_q <= 8'h00;
         flags1_q <= 1'b0;
         int_q <= 1'b0;
      end
      else
      begin
         if (wr_en0)
            en0_q <= wdata_q;
         if (wr_en1)
            en1_q <= wdata_q[0];
         // a new overflow beats a clear in the same cycle
         flags0_q <= (flags0_q & ~(wr_fl0 ? wdata_q : 8'h00)) | ovf_evt_i;
         flags1_q <= (flags1_q & ~(wr_fl1 & wdata_q[0])) | line_code_ovf_evt_i;
         int_q <= any_irq;
      end
   end
   assign int_n_o = ~int_q;

   ////////////////////////////////////////////////////////////////////////////////
   // pattern test configuration
   wire [1:0] tmode = test_cfg_q[3:2];
   wire [6:0] slot_cfg_addr = {2'b10, slot_idx_i};
   wire slot_cfg_ok = (slot_idx_i[3:0] != 4'h0);
   wire [7:0] slot_cfg = slot_cfg_ok ? mem_q[slot_cfg_addr] : 8'h00;
   wire slot_test = slot_cfg[`SLOT_TEST_BIT];
   wire [7:0] mask_d =
      (tmode == e1_tx_payload_pkg::TEST_UNFRAMED) ? 8'hFF :
      (tmode == e1_tx_payload_pkg::TEST_8BIT) ? (slot_test ? 8'hFF : 8'h00) :
      (tmode == e1_tx_payload_pkg::TEST_7BIT) ? (slot_test ? 8'hFE : 8'h00) : 8'h00;

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         test_cfg_q <= 4'h0;
         test_prev_q <= 1'b0;
         test_start_q <= 1'b0;
         test_mask_q <= 8'h00;
      end
      else
      begin
         if (wr_test)
            test_cfg_q <= wdata_q[3:0];
         test_prev_q <= test_cfg_q[`TEST_START_BIT];
         test_start_q <= test_cfg_q[`TEST_START_BIT] & ~test_prev_q;
         if (slot_strobe_i)
            test_mask_q <= mask_d;
      end
   end
   assign test_start_o = test_start_q;
   assign test_gen_tx_o = ~test_cfg_q[`TEST_DIR_BIT];
   assign test_gen_rx_o = test_cfg_q[`TEST_DIR_BIT];
   assign test_mask_o = test_mask_q;

   ////////////////////////////////////////////////////////////////////////////////
   // indirect access window
   wire [6:0] acc_addr = acc_ctrl_q[6:0];
   wire acc_read = acc_ctrl_q[`ACC_DIR_BIT];
   wire acc_addr_ok = (acc_addr <= `ID_LAST) && (acc_addr != `ID_HOLE0)
                      && (acc_addr != `ID_HOLE1);
   // a control write while busy is dropped so the running access stays intact
   wire acc_start = wr_ctrl & ~busy;
   wire acc_done = busy && (acc_cnt_q == `ACC_CYCLES - 2'h1);

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         acc_state_q <= e1_tx_payload_pkg::ACC_IDLE;
         acc_cnt_q <= 2'h0;
         acc_ctrl_q <= 8'h00;
      end
      else
      begin
         case (acc_state_q)
            e1_tx_payload_pkg::ACC_IDLE:
            begin
               acc_cnt_q <= 2'h0;
               if (acc_start)
               begin
                  acc_ctrl_q <= wdata_q;
                  acc_state_q <= e1_tx_payload_pkg::ACC_RUN;
               end
            end
            e1_tx_payload_pkg::ACC_RUN:
            begin
               acc_cnt_q <= acc_cnt_q + 2'h1;
               if (acc_done)
                  acc_state_q <= e1_tx_payload_pkg::ACC_IDLE;
            end
            default:
               acc_state_q <= e1_tx_payload_pkg::ACC_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
         acc_data_q <= 8'h00;
      else if (acc_done && acc_read)
         acc_data_q <= acc_addr_ok ? mem_q[acc_addr] : 8'h00;
      else if (wr_data && !busy)
         acc_data_q <= wdata_q;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < 128; i++)
            mem_q[i] <= 8'h00;
      end
      else if (acc_done && !acc_read && acc_addr_ok)
         mem_q[acc_addr] <= acc_data_q;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // payload and signaling replacement
   function automatic logic [7:0] alaw_mw(input logic [2:0] p);
      case (p)
         3'h0, 3'h3: alaw_mw = 8'h34;
         3'h1, 3'h2: alaw_mw = 8'h21;
         3'h4, 3'h7: alaw_mw = 8'hB4;
         default: alaw_mw = 8'hA1;
      endcase
   endfunction

   function automatic logic [7:0] mulaw_mw(input logic [2:0] p);
      case (p)
         3'h0, 3'h3: mulaw_mw = 8'h1E;
         3'h1, 3'h2: mulaw_mw = 8'h0B;
         3'h4, 3'h7: mulaw_mw = 8'h9E;
         default: mulaw_mw = 8'h8B;
      endcase
   endfunction

   wire [2:0] gsub = pl_cfg_q[2:0];
   wire [2:0] slot_sub = mem_q[{2'b00, slot_idx_i}][7:5];
   wire [7:0] trunk = mem_q[{2'b01, slot_idx_i}];
   wire [2:0] eff_sub = (gsub == e1_tx_payload_pkg::REPL_SLOT) ? slot_sub : gsub;
   wire [7:0] data_repl =
      (eff_sub == e1_tx_payload_pkg::REPL_TRUNK) ? trunk :
      (eff_sub == e1_tx_payload_pkg::REPL_ALAW) ? alaw_mw(frame_idx_i[2:0]) :
      (eff_sub == e1_tx_payload_pkg::REPL_MULAW) ? mulaw_mw(frame_idx_i[2:0]) :
      (eff_sub == e1_tx_payload_pkg::REPL_LOOP) ? loopback_data_i : tx_data_i;
   wire snap_on = pl_cfg_q[`CFG_SNAP_BIT];
   wire first_frame = (frame_idx_i == 4'h0);
   wire [3:0] sig_src = (snap_on && !first_frame) ? snap_q[slot_idx_i] : tx_sig_i;
   wire sig_cond = pl_cfg_q[`CFG_GSIG_BIT] | slot_cfg[`SLOT_SIG_BIT];
   wire [3:0] sig_repl = sig_cond ? slot_cfg[3:0] : sig_src;

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         pl_cfg_q <= `CFG_RESET;
         pl_en_q <= 1'b0;
      end
      else
      begin
         if (wr_cfg)
            pl_cfg_q <= wdata_q & `CFG_WMASK;
         if (wr_pen)
            pl_en_q <= wdata_q[0];
      end
   end

   // snapshot store has no reset: it is read on every frame but the first while snapshot is on, even before any first frame has refilled it
   always_ff @(posedge mclk_i)
   begin
      if (slot_strobe_i && first_frame)
         snap_q[slot_idx_i] <= tx_sig_i;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         tx_data_q <= 8'h00;
         tx_sig_q <= 4'h0;
      end
      else if (slot_strobe_i)
      begin
         tx_data_q <= pl_en_q ? data_repl : tx_data_i;
         tx_sig_q <= pl_en_q ? sig_repl : tx_sig_i;
      end
   end
   assign tx_data_o = tx_data_q;
   assign tx_sig_o = tx_sig_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_int;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (flags1_q && !en1_q && irq_src == 8'h00) |=> int_n_o;
   endproperty
   a_int: assert property (p_int) else $error("masked flag drove interrupt");

   property p_flag_set;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (ovf_evt_i != 8'h00) |=> ((flags0_q & $past(ovf_evt_i)) == $past(ovf_evt_i));
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("overflow not flagged");

   property p_flag_sticky;
      @(posedge mclk_i) disable iff (!rst_n_i)
      !wr_fl0 |=> ((flags0_q & $past(flags0_q)) == $past(flags0_q));
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

   property p_lcv_set;
      @(posedge mclk_i) disable iff (!rst_n_i)
      line_code_ovf_evt_i |=> flags1_q ##1 (flags1_q || $past(wr_fl1));
   endproperty
   a_lcv_set: assert property (p_lcv_set) else $error("line code flag");

   property p_unframed;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (slot_strobe_i && tmode == 2'h0) |=> (test_mask_o == 8'hFF);
   endproperty
   a_unframed: assert property (p_unframed) else $error("unframed mask");

   property p_start_edge;
      @(posedge mclk_i) disable iff (!rst_n_i)
      test_start_o |-> ($past(test_cfg_q[0]) && !$past(test_cfg_q[0], 2)) ##1 !test_start_o;
   endproperty
   a_start_edge: assert property (p_start_edge) else $error("start without edge");

   property p_busy_len;
      @(posedge mclk_i) disable iff (!rst_n_i)
      acc_start |=> busy [*2] ##1 !busy;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length");

   property p_read_data;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (acc_done && acc_read && acc_addr_ok) |=> (acc_data_q == $past(mem_q[acc_addr]));
   endproperty
   a_read_data: assert property (p_read_data) else $error("read data not loaded");

   property p_bypass;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (slot_strobe_i && !pl_en_q) |=> (tx_data_o == $past(tx_data_i)
                                       && tx_sig_o == $past(tx_sig_i));
   endproperty
   a_bypass: assert property (p_bypass) else $error("disabled path altered");

   property p_trunk;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (slot_strobe_i && pl_en_q && gsub == 3'h1) |=> (tx_data_o == $past(trunk));
   endproperty
   a_trunk: assert property (p_trunk) else $error("trunk code missing");
endmodule // e1_tx_payload_ctrl_regs
`default_nettype wire

// >>> dummy_end_marker_unused.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> e1_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module e1_host_model
(
   input wire logic mclk_i,
   output logic [11:0] awaddr_o,
   output logic awvalid_o,
   input wire logic awready_i,
   output logic [31:0] wdata_o,
   output logic [3:0] wstrb_o,
   output logic wvalid_o,
   input wire logic wready_i,
   input wire logic [1:0] bresp_i,
   input wire logic bvalid_i,
   output logic bready_o,
   output logic [11:0] araddr_o,
   output logic arvalid_o,
   input wire logic arready_i,
   input wire logic [31:0] rdata_i,
   input wire logic [1:0] rresp_i,
   input wire logic rvalid_i,
   output logic rready_o
);
   initial
   begin
      {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
      {araddr_o, arvalid_o, rready_o} = '0;
      wstrb_o = 4'hF;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // released payload is inverted so a stale value never looks valid
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
      @(posedge mclk_i);
      awaddr_o <= {2'h0, idx, 2'h0};
      wdata_o <= {24'h000000, d};
      {awvalid_o, wvalid_o, bready_o} <= 3'h7;
      do
      begin
         @(posedge mclk_i);
         if (awvalid_o && awready_i)
            {awvalid_o, awaddr_o} <= {1'b0, ~awaddr_o};
         if (wvalid_o && wready_i)
            {wvalid_o, wdata_o} <= {1'b0, ~wdata_o};
      end while (bvalid_i !== 1'b1);
      r = bresp_i;
      bready_o <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk_i);
      araddr_o <= {2'h0, idx, 2'h0};
      {arvalid_o, rready_o} <= 2'h3;
      do
      begin
         @(posedge mclk_i);
         if (arvalid_o && arready_i)
            {arvalid_o, araddr_o} <= {1'b0, ~araddr_o};
      end while (rvalid_i !== 1'b1);
      d = rdata_i;
      r = rresp_i;
      rready_o <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // one indirect access; returns the first status poll
   task automatic acc(input logic rd_n, input logic [6:0] a, input logic [7:0] wd,
                      output logic [31:0] busy1, output logic [31:0] rdv);
      logic [1:0] r;
      logic [1:0] r2;
      logic [31:0] s;
      int n;
      if (!rd_n)
         wr(8'hCA, wd, r);
      // busy lasts two cycles only, so the first poll rides alongside the write
      fork
         wr(8'hC9, {rd_n, a}, r);
         begin
            repeat (2) @(posedge mclk_i);
            rd(8'hC8, s, r2);
         end
      join
      busy1 = s;
      n = 0;
      while (s[0] !== 1'b0 && n < 20)
      begin
         rd(8'hC8, s, r);
         n++;
      end
      rdv = 32'h00000000;
      if (rd_n)
         rd(8'hCA, rdv, r);
   endtask
endmodule // e1_host_model
`default_nettype wire

// >>> e1_tx_payload_ctrl_regs_bench.sv
`timescale 1ns/1ns
`include "e1_tx_payload_consts.svh"
`default_nettype none
module e1_tx_payload_ctrl_regs_bench;
   logic mclk_i, rst_n_i, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
   logic lc, int_n, t_start, gen_tx, gen_rx, strobe;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdt, v, busy;
   logic [3:0] ws, txs, txs_o, fidx;
   logic [1:0] bresp, rresp, r;
   logic [7:0] ovf, txd, lbd, txd_o, mask, b;
   logic [4:0] sidx;
   int failures = 0, tests_run = 0, pulses = 0, cfg = 'h80, tcfg = 0, en = 0;
   int mem [128];
   int cap [32];
   int sl [$];
   int alaw [8] = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};
   int mulaw [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
   e1_host_model i_host (.mclk_i(mclk_i), .awaddr_o(awa), .awvalid_o(awv), .awready_i(awr),
      .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .wready_i(wrd), .bresp_i(bresp),
      .bvalid_i(bv), .bready_o(br), .araddr_o(ara), .arvalid_o(arv), .arready_i(arr),
      .rdata_i(rdt), .rresp_i(rresp), .rvalid_i(rv), .rready_o(rr));
   e1_tx_payload_ctrl_regs i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .ovf_evt_i(ovf), .line_code_ovf_evt_i(lc),
      .int_n_o(int_n), .test_start_o(t_start), .test_gen_tx_o(gen_tx),
      .test_gen_rx_o(gen_rx), .test_mask_o(mask), .slot_strobe_i(strobe),
      .slot_idx_i(sidx), .frame_idx_i(fidx), .tx_data_i(txd), .tx_sig_i(txs),
      .loopback_data_i(lbd), .tx_data_o(txd_o), .tx_sig_o(txs_o));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i)
      if (t_start === 1'b1)
         pulses++;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic settle;
      repeat (3) @(posedge mclk_i);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // one timeslot through the payload path against the integer model
   task automatic slot(input int s, input int f);
      int code, ed, es, em, st;
      logic [7:0] d, lb;
      logic [3:0] sv;
      d = 8'($urandom);
      lb = 8'($urandom);
      sv = 4'($urandom);
      @(posedge mclk_i);
      {strobe, sidx, fidx, txd, txs, lbd} <= {1'b1, 5'(s), 4'(f), d, sv, lb};
      @(posedge mclk_i);
      {strobe, txd, txs, lbd} <= {1'b0, ~d, ~sv, ~lb};
      #1;
      code = (cfg & 7) != 0 ? cfg & 7 : mem[s] >> 5;
      ed = code == 1 ? mem[32 + s] : code == 2 ? alaw[f % 8] : code == 3 ? mulaw[f % 8] : d;
      ed = code == 4 ? lb : ed;
      if (f == 0)
         cap[s] = sv;
      st = mem[64 + s];
      es = ((cfg >> 7) & 1) && f != 0 ? cap[s] : sv;
      es = ((cfg >> 6) & 1) || ((st >> 4) & 1) ? st & 15 : es;
      em = (tcfg >> 2) == 0 ? 'hFF : (tcfg >> 2) == 3 || !((st >> 6) & 1) ? 0 : 'hFF;
      em = (tcfg >> 2) == 2 ? em & 'hFE : em;
      chk(txd_o, en ? ed : d);
      chk(txs_o, en ? es : sv);
      if (en)
         chk(mask, em);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_n_i, ovf, lc, strobe, sidx, fidx, txd, txs, lbd} = '0;
      foreach (mem[i])
         mem[i] = 0;
      void'($urandom(89993));
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < 10; i++)
      begin
         i_host.rd(8'(8'hC3 + i), v, r);
         chk(v, i == 8 ? 32'h80 : 32'h0);
      end
      chk(int_n, 1'b1);
      i_host.rd(8'h10, v, r);
      chk({30'h0, r}, {30'h0, `RESP_SLVERR});
      chk(v, 32'h0);
      // overflow flags: sticky, write one to clear, gated into the interrupt
      b = 8'($urandom) | 8'h01;
      @(posedge mclk_i) {ovf, lc} <= {b, 1'b1};
      @(posedge mclk_i) {ovf, lc} <= 9'h000;
      settle();
      chk(int_n, 1'b1);
      i_host.rd(8'hC6, v, r);
      chk(v, 32'h1);
      i_host.wr(8'hC3, 8'hFF, r);
      chk({30'h0, r}, {30'h0, `RESP_OKAY});
      settle();
      chk(int_n, 1'b0);
      i_host.wr(8'hC5, 8'h00, r);
      i_host.rd(8'hC5, v, r);
      chk(v, b);
      i_host.wr(8'hC5, b, r);
      i_host.rd(8'hC5, v, r);
      chk(v, 32'h0);
      settle();
      chk(int_n, 1'b1);
      i_host.wr(8'hC4, 8'h01, r);
      settle();
      chk(int_n, 1'b0);
      i_host.wr(8'hC6, 8'h01, r);
      settle();
      chk(int_n, 1'b1);
      // start bit edge versus static level
      i_host.wr(8'hC7, 8'h01, r);
      settle();
      chk(pulses, 1);
      i_host.wr(8'hC7, 8'h01, r);
      settle();
      chk(pulses, 1);
      i_host.wr(8'hC7, 8'h00, r);
      // indirect store on a few slots, legal addresses only
      sl.push_back(0);
      for (int k = 0; k < 4; k++)
         sl.push_back(1 + $urandom % 15);
      foreach (sl[j])
         for (int a = sl[j]; a < 96 && sl[j] != 0; a += 32)
         begin
            b = 8'($urandom);
            mem[a] = b;
            i_host.acc(1'b0, 7'(a), b, busy, v);
            chk(busy, 32'h1);
            i_host.acc(1'b1, 7'(a), 8'h00, busy, v);
            chk(v, b);
            i_host.rd(8'hC9, v, r);
            chk(v, 8'h80 | a);
         end
      slot(sl[1], 0);
      i_host.wr(8'hCC, 8'h01, r);
      en = 1;
      for (int g = 0; g < 6; g++)
      begin
         cfg = g | ($urandom % 4) << 6;
         tcfg = (g % 4) << 2 | (g & 1) << 1;
         i_host.wr(8'hCB, 8'(cfg), r);
         i_host.wr(8'hC7, 8'(tcfg), r);
         i_host.rd(8'hCB, v, r);
         chk(v, cfg);
         chk({gen_tx, gen_rx}, (tcfg & 2) ? 2'h1 : 2'h2);
         foreach (sl[j])
            for (int f = 0; f < 8; f++)
               slot(sl[j], f);
      end
      test_done();
   end
   initial
   begin
      #1500000;
      failures++;
      test_done();
   end
endmodule // e1_tx_payload_ctrl_regs_bench
`default_nettype wire
